// ### core/clu_defs.svh
// Constants for the console line block: offsets, fields, resets, timing
// Overview of operation
// - Seven or eight data bits, default eight
// - Seven-bit receive drops the top bit
// - Parity none, even or odd, default none
// - Rates 9600 to 115200, default 9600
// - One rate for transmit and receive
// - Unsupported rate rejected and reported
// - One or two stop bits, default one
// - Idle timer ends session, zero disables
// - Failed logon threshold, zero unlimited, default three
// - Silent period after threshold, default none
`ifndef CLU_DEFS_SVH
`define CLU_DEFS_SVH
`define CLU_CLK_HZ        10000000
`define CLU_OVS           16
`define CLU_A_CFG         12'h000
`define CLU_A_RATE        12'h004
`define CLU_A_STAT        12'h008
`define CLU_A_MASK        12'h00C
`define CLU_A_TXD         12'h010
`define CLU_A_RXD         12'h014
`define CLU_A_IDLE        12'h018
`define CLU_A_THR         12'h01C
`define CLU_A_SIL         12'h020
`define CLU_A_LOGON       12'h024
`define CLU_CFG_RST       5'h01
`define CLU_RATE_RST      17'h02580
`define CLU_THR_RST       7'h03
`define CLU_ST_RXDONE     0
`define CLU_ST_TXDONE     1
`define CLU_ST_PERR       2
`define CLU_ST_FERR       3
`define CLU_ST_BADRATE    4
`define CLU_ST_IDLE       5
`define CLU_ST_LOCK       6
`define CLU_ST_W          7
`define CLU_LOG_FAIL      0
`define CLU_LOG_OK        1
`endif

// ### core/clu_pkg.sv
// Types shared by the console line block
package clu_pkg;
	typedef enum logic [1:0] {
		CLU_PAR_NONE,
		CLU_PAR_EVEN,
		CLU_PAR_ODD,
		CLU_PAR_RSVD
	} clu_par_e;
	typedef enum {
		CLU_S_IDLE,
		CLU_S_START,
		CLU_S_DATA,
		CLU_S_PAR,
		CLU_S_STOP
	} clu_state_e;
endpackage : clu_pkg

// ### core/clu_sec_timer.sv
// Seconds down-counter used for idle and silent periods
`timescale 1ns/1ps
module clu_sec_timer #(
	parameter int SEC_CYCLES = 10000000
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        load,
	input  wire logic [15:0] secs,
	output logic             busy,
	output logic             expire
);
	logic [23:0] pre_r;
	logic [15:0] cnt_r;
	wire         sec_tick = (pre_r == 24'h000000);

	// Prescaler reloads every second, counter counts seconds down
	always_ff @(posedge clk_sys) begin
		if (!nrst || load) begin
			pre_r <= 24'(SEC_CYCLES - 1);
			cnt_r <= nrst ? secs : 16'h0000;
		end else if (cnt_r != 16'h0000) begin
			pre_r <= sec_tick ? 24'(SEC_CYCLES - 1) : pre_r - 24'h000001;
			if (sec_tick) begin
				cnt_r <= cnt_r - 16'h0001;
			end
		end
	end
	assign busy   = (cnt_r != 16'h0000);
	assign expire = busy && sec_tick && (cnt_r == 16'h0001);
endmodule : clu_sec_timer

// ### core/clu_top.sv
// Console line UART with APB registers, idle timer and logon lockout
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "clu_defs.svh"
module clu_top #(
	parameter int SEC_CYCLES = `CLU_CLK_HZ
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq,
	output logic             session_end,
	output logic             logon_silent
);
	// Config: [0] eight bits, [2:1] parity, [3] two stops
	logic [3:0]  cfg_r;
	logic [16:0] rate_r;
	logic [7:0]  rxdata_r;
	logic [`CLU_ST_W-1:0] stat_r, stat_nxt, mask_r;
	logic [15:0] idle_r, sil_r;
	logic [6:0]  thr_r, fails_r;
	logic [10:0] div_r, div_nxt;
	logic [10:0] tick_cnt_r;
	logic        tick;
	logic        rx_s1_r, rx_s2_r, rx_prev_r;
	logic [31:0] prdata_r;

	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire hit_cfg   = (paddr == `CLU_A_CFG);
	wire hit_rate  = (paddr == `CLU_A_RATE);
	wire hit_stat  = (paddr == `CLU_A_STAT);
	wire hit_mask  = (paddr == `CLU_A_MASK);
	wire hit_txd   = (paddr == `CLU_A_TXD);
	wire hit_rxd   = (paddr == `CLU_A_RXD);
	wire hit_idle  = (paddr == `CLU_A_IDLE);
	wire hit_thr   = (paddr == `CLU_A_THR);
	wire hit_sil   = (paddr == `CLU_A_SIL);
	wire hit_logon = (paddr == `CLU_A_LOGON);
	wire hit_any = hit_cfg || hit_rate || hit_stat || hit_mask || hit_txd || hit_rxd
		|| hit_idle || hit_thr || hit_sil || hit_logon;
	wire [16:0] new_rate = pwdata[16:0];
	// High bits must be clear, or a large value could alias a legal rate
	wire rate_hi_zero = (pwdata[31:17] == 15'h0000);
	wire rate_ok = rate_hi_zero && ((new_rate == 17'd9600) || (new_rate == 17'd19200)
		|| (new_rate == 17'd38400) || (new_rate == 17'd57600) || (new_rate == 17'd115200));
	wire rate_bad = wr_en && hit_rate && !rate_ok;
	wire lock_busy;
	// Whole word compared, so a large value is refused rather than cut
	wire thr_write_ok = (pwdata <= 32'd120);

	// Zero wait states; every access ends in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!hit_any || rate_bad
		|| (pwrite && hit_thr && !thr_write_ok));

	// oversample divisor from selected rate
	// Truncated divisor, so the top rate runs fast at this clock
	always_comb begin
		div_nxt = 11'(`CLU_CLK_HZ / (`CLU_OVS * 9600));
		if (rate_r == 17'd19200) begin
			div_nxt = 11'(`CLU_CLK_HZ / (`CLU_OVS * 19200));
		end else if (rate_r == 17'd38400) begin
			div_nxt = 11'(`CLU_CLK_HZ / (`CLU_OVS * 38400));
		end else if (rate_r == 17'd57600) begin
			div_nxt = 11'(`CLU_CLK_HZ / (`CLU_OVS * 57600));
		end else if (rate_r == 17'd115200) begin
			div_nxt = 11'(`CLU_CLK_HZ / (`CLU_OVS * 115200));
		end
	end

	always_ff @(posedge clk_sys) begin
		div_r <= div_nxt;
		if (!nrst || tick_cnt_r == 11'h000) begin
			tick_cnt_r <= div_r - 11'h001;
		end else begin
			tick_cnt_r <= tick_cnt_r - 11'h001;
		end
	end
	assign tick = nrst && (tick_cnt_r == 11'h000);

	// Pin synchroniser, second stage is the first one read
	always_ff @(posedge clk_sys) begin
		rx_s1_r   <= nrst ? rxd : 1'b1;
		rx_s2_r   <= nrst ? rx_s1_r : 1'b1;
		rx_prev_r <= nrst ? rx_s2_r : 1'b1;
	end

	// Receiver
	clu_pkg::clu_state_e rx_st_r;
	logic [3:0] rx_ph_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	logic       rx_par_r;
	logic       rx_done, rx_perr, rx_ferr;
	wire  [2:0] last_bit = cfg_r[0] ? 3'h7 : 3'h6;
	wire        par_on = (cfg_r[2:1] != 2'h0);
	wire        mid = tick && (rx_ph_r == 4'h7);
	wire  [7:0] rx_char = cfg_r[0] ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
	// expected parity from setting
	// Taken over the kept bits only; in seven-bit mode the low shifter
	// bit still holds a bit of the frame before
	wire        par_exp = (^rx_char) ^ (cfg_r[2:1] == 2'(clu_pkg::CLU_PAR_ODD));

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rx_st_r  <= clu_pkg::CLU_S_IDLE;
			rx_ph_r  <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r  <= 8'h00;
			rx_par_r <= 1'b0;
		end else begin
			if (tick) begin
				rx_ph_r <= rx_ph_r + 4'h1;
			end
			case (rx_st_r)
				clu_pkg::CLU_S_IDLE: begin
					if (rx_prev_r && !rx_s2_r) begin
						rx_st_r <= clu_pkg::CLU_S_START;
						rx_ph_r <= 4'h0;
					end
				end
				clu_pkg::CLU_S_START: begin
					if (mid) begin
						rx_st_r  <= rx_s2_r ? clu_pkg::CLU_S_IDLE : clu_pkg::CLU_S_DATA;
						rx_bit_r <= 3'h0;
					end
				end
				clu_pkg::CLU_S_DATA: begin
					if (mid) begin
						rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == last_bit) begin
							rx_st_r <= par_on ? clu_pkg::CLU_S_PAR : clu_pkg::CLU_S_STOP;
						end
					end
				end
				clu_pkg::CLU_S_PAR: begin
					if (mid) begin
						rx_par_r <= rx_s2_r;
						rx_st_r  <= clu_pkg::CLU_S_STOP;
					end
				end
				clu_pkg::CLU_S_STOP: begin
					if (mid) begin
						rx_st_r <= clu_pkg::CLU_S_IDLE;
					end
				end
				default: rx_st_r <= clu_pkg::CLU_S_IDLE;
			endcase
		end
	end
	assign rx_done = mid && (rx_st_r == clu_pkg::CLU_S_STOP);
	assign rx_perr = rx_done && par_on && (rx_par_r != par_exp);
	assign rx_ferr = rx_done && !rx_s2_r;

	// Transmitter; frame bits built once so the shifter stays simple
	logic [11:0] tx_sh_r;
	logic [3:0]  tx_left_r;
	logic [3:0]  tx_ph_r;
	logic        tx_done;
	wire         tx_busy = (tx_left_r != 4'h0);
	// A data write while busy is dropped, not queued
	wire         tx_go = wr_en && hit_txd && !tx_busy;
	wire  [7:0]  tx_dat = cfg_r[0] ? pwdata[7:0] : {1'b0, pwdata[6:0]};
	wire         tx_par = (^tx_dat) ^ (cfg_r[2:1] == 2'(clu_pkg::CLU_PAR_ODD));
	// frame length from width, parity and stops
	wire  [3:0]  tx_len = (cfg_r[0] ? 4'h9 : 4'h8) + {3'h0, par_on}
		+ {3'h0, cfg_r[3]};
	wire  [11:0] tx_frame = cfg_r[0]
		? (par_on ? {2'b11, tx_par, tx_dat, 1'b0} : {3'b111, tx_dat, 1'b0})
		: (par_on ? {3'b111, tx_par, tx_dat[6:0], 1'b0} : {4'hF, tx_dat[6:0], 1'b0});

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tx_sh_r   <= 12'hFFF;
			tx_left_r <= 4'h0;
			tx_ph_r   <= 4'h0;
		end else if (tx_go) begin
			tx_sh_r   <= tx_frame;
			tx_left_r <= tx_len + 4'h1;
			tx_ph_r   <= 4'h0;
		end else if (tx_busy && tick) begin
			tx_ph_r <= tx_ph_r + 4'h1;
			if (tx_ph_r == 4'hF) begin
				tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
				tx_left_r <= tx_left_r - 4'h1;
			end
		end
	end
	assign tx_done = tx_busy && tick && (tx_ph_r == 4'hF) && (tx_left_r == 4'h1);
	assign txd = tx_sh_r[0];

	// Logon failures and lockout
	wire log_wr   = wr_en && hit_logon && !lock_busy;
	wire log_fail = log_wr && pwdata[`CLU_LOG_FAIL];
	wire log_ok   = log_wr && pwdata[`CLU_LOG_OK];
	wire thr_hit  = log_fail && (thr_r != 7'h00) && (fails_r + 7'h01 >= thr_r);
	wire lock_start = thr_hit && (sil_r != 16'h0000);

	// Success and reaching the limit both restart the count
	always_ff @(posedge clk_sys) begin
		if (!nrst || log_ok || thr_hit) begin
			fails_r <= 7'h00;
		end else if (log_fail) begin
			fails_r <= fails_r + 7'h01;
		end
	end

	clu_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_silent (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.load    (lock_start),
		.secs    (sil_r),
		.busy    (lock_busy),
		.expire  ()
	);
	assign logon_silent = lock_busy;

	// idle timer restarts on input
	// A write loads the new span at once, not only on input
	wire idle_exp;
	clu_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_idle (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.load    (rx_done || (wr_en && hit_idle)),
		.secs    ((wr_en && hit_idle) ? pwdata[15:0] : idle_r),
		.busy    (),
		.expire  (idle_exp)
	);
	assign session_end = idle_exp;

	// Sticky status, set beats write-one clear
	always_comb begin
		stat_nxt = stat_r;
		if (wr_en && hit_stat) begin
			stat_nxt = stat_r & ~pwdata[`CLU_ST_W-1:0];
		end
		stat_nxt[`CLU_ST_RXDONE]  = stat_nxt[`CLU_ST_RXDONE] | rx_done;
		stat_nxt[`CLU_ST_TXDONE]  = stat_nxt[`CLU_ST_TXDONE] | tx_done;
		stat_nxt[`CLU_ST_PERR]    = stat_nxt[`CLU_ST_PERR] | rx_perr;
		stat_nxt[`CLU_ST_FERR]    = stat_nxt[`CLU_ST_FERR] | rx_ferr;
		stat_nxt[`CLU_ST_BADRATE] = stat_nxt[`CLU_ST_BADRATE] | rate_bad;
		stat_nxt[`CLU_ST_IDLE]    = stat_nxt[`CLU_ST_IDLE] | idle_exp;
		stat_nxt[`CLU_ST_LOCK]    = stat_nxt[`CLU_ST_LOCK] | lock_start;
	end

	// Register writes; a rejected rate keeps the old one
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cfg_r    <= 4'(`CLU_CFG_RST);
			rate_r   <= `CLU_RATE_RST;
			stat_r   <= '0;
			mask_r   <= '0;
			idle_r   <= 16'h0000;
			thr_r    <= `CLU_THR_RST;
			sil_r    <= 16'h0000;
			rxdata_r <= 8'h00;
		end else begin
			stat_r <= stat_nxt;
			if (rx_done) rxdata_r <= rx_char;
			if (wr_en && hit_cfg) cfg_r <= pwdata[3:0];
			if (wr_en && hit_rate && rate_ok) rate_r <= new_rate;
			if (wr_en && hit_mask) mask_r <= pwdata[`CLU_ST_W-1:0];
			if (wr_en && hit_idle) idle_r <= pwdata[15:0];
			if (wr_en && hit_thr && thr_write_ok) thr_r <= pwdata[6:0];
			if (wr_en && hit_sil) sil_r <= pwdata[15:0];
		end
	end

	// Read mux registered onto prdata
	wire [31:0] rd_val = hit_cfg ? {28'h0, cfg_r}
		: hit_rate  ? {15'h0, rate_r}
		: hit_stat  ? {25'h0, stat_r}
		: hit_mask  ? {25'h0, mask_r}
		: hit_txd   ? {31'h0, tx_busy}
		: hit_rxd   ? {24'h0, rxdata_r}
		: hit_idle  ? {16'h0, idle_r}
		: hit_thr   ? {25'h0, thr_r}
		: hit_sil   ? {16'h0, sil_r}
		: hit_logon ? {18'h0, fails_r, 6'h0, lock_busy}
		: 32'h0;
	always_ff @(posedge clk_sys) begin
		prdata_r <= (!nrst) ? 32'h0 : (psel && !pwrite ? rd_val : prdata_r);
		irq      <= nrst && |(stat_nxt & mask_r);
	end
	assign prdata = rd_en ? prdata_r : 32'h0;
endmodule : clu_top

// ### testbench/clu_chk.sv
// Port-level assertion checker for the console line block
`timescale 1ns/1ps
`include "clu_defs.svh"
module clu_chk (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        irq,
	input wire logic        session_end,
	input wire logic        logon_silent
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Access phase and write strobe
	wire acc = psel && penable;
	wire wrs = acc && pwrite;
	chk_rate_refuse: assert property (wrs && paddr == `CLU_A_RATE |-> pslverr ==
		!(pwdata inside {32'd9600, 32'd19200, 32'd38400, 32'd57600, 32'd115200}))
		else $error("rate refusal wrong");
	chk_thr_refuse: assert property (wrs && paddr == `CLU_A_THR |->
		pslverr == (pwdata > 32'd120))
		else $error("threshold refusal wrong");
	chk_irq_masked: assert property (wrs && paddr == `CLU_A_MASK && pwdata[6:0] == 7'h00
		|=> ##1 !irq)
		else $error("irq high with mask clear");
	chk_reset_idle: assert property ($rose(nrst) |->
		txd && !irq && !session_end && !logon_silent)
		else $error("outputs not idle after reset");
	chk_idle_pulse: assert property (session_end |=> !session_end)
		else $error("session end longer than one cycle");
	chk_read_zero: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside read access");
	chk_unmapped: assert property (acc && paddr > `CLU_A_LOGON |-> pslverr)
		else $error("unmapped access not refused");
	chk_silent_hold: assert property ($rose(logon_silent) |-> logon_silent[*8])
		else $error("silent period too short");
endmodule : clu_chk
bind clu_top clu_chk chk_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq), .session_end(session_end),
	.logon_silent(logon_silent));

// ### testbench/clu_term.sv
// Serial terminal model on the console line
`timescale 1ns/1ps
module clu_term (
	input wire logic clk_sys,
	input wire logic txd,
	output logic     rxd
);
	// Line idles at mark level
	initial rxd = 1'b1;
	// same bit rate
	// Frames are prepared by the caller, so bad parity or stop is easy
	task automatic send(input logic [11:0] f, input int n, input int bc);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (bc) @(posedge clk_sys);
		end
		rxd <= 1'b1;
	endtask : send
	// same bit rate
	// Capture n bits near their centres, start bit first
	task automatic recv(input int n, input int bc, output logic [11:0] f);
		int w;
		w = 0;
		f = 12'hFFF;
		while (txd === 1'b1 && w < 20000) begin
			@(posedge clk_sys);
			w++;
		end
		repeat (bc / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			f[i] = txd;
			repeat (bc) @(posedge clk_sys);
		end
	endtask : recv
endmodule : clu_term

// ### testbench/tb_console_line_uart.sv
// Self-checking bench for the console line block
`timescale 1ns/1ps
`include "clu_defs.svh"
module tb_console_line_uart;
	logic        clk_sys;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic        session_end;
	logic        logon_silent;
	logic [31:0] rv;
	logic        er;
	logic [11:0] fr;
	int          errors;
	int          compares;
	int          t;
	int          rt[5] = '{9600, 19200, 38400, 57600, 115200};
	logic [3:0]  cf[3] = '{4'h1, 4'hA, 4'h5};
	// Short second keeps timer runs brief
	clu_top #(.SEC_CYCLES(20)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.irq(irq), .session_end(session_end), .logon_silent(logon_silent));
	clu_term term_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
	// 100 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Counts, verdict, end of run
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic ck(input string n, input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask : ck
	// One APB transfer; the idle edge after it keeps strobes from colliding
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		ck(n, rv, x);
	endtask : rd
	// Expected line frame: start, data LSB first, parity, stop ones
	function automatic logic [11:0] frm(input logic [7:0] d, input int nb,
		input logic [1:0] pm);
		logic [11:0] f;
		logic        p;
		f = 12'hFFF;
		f[0] = 1'b0;
		p = pm[1];
		for (int i = 0; i < nb; i++) begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		if (pm != 2'h0)
			f[nb + 1] = p;
		return f;
	endfunction : frm
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		nrst = 1'b0;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rd(`CLU_A_CFG, 32'h1, "cfg");
		rd(`CLU_A_RATE, 32'h2580, "rate");
		rd(`CLU_A_THR, 32'h3, "thr");
		rd(`CLU_A_SIL, 32'h0, "silent");
		rd(12'h028, 32'h0, "unmapped");
		ck("unmapped err", er, 1);
		wr(`CLU_A_RATE, 32'd14400);
		ck("bad rate err", er, 1);
		rd(`CLU_A_RATE, 32'h2580, "rate kept");
		rd(`CLU_A_STAT, 32'h10, "bad rate stat");
		ck("irq masked", irq, 0);
		// Irq follows the mask register one edge after the write lands
		wr(`CLU_A_MASK, 32'h10);
		@(posedge clk_sys);
		ck("irq set", irq, 1);
		wr(`CLU_A_MASK, 32'h0);
		@(posedge clk_sys);
		ck("irq off", irq, 0);
		wr(`CLU_A_STAT, 32'h10);
		wr(`CLU_A_MASK, 32'h10);
		@(posedge clk_sys);
		ck("irq cleared", irq, 0);
		foreach (rt[i]) begin
			wr(`CLU_A_RATE, rt[i]);
			ck("rate err", er, 0);
			rd(`CLU_A_RATE, rt[i], "rate");
		end
		// Three frame shapes at 115200, bit period 80 cycles
		foreach (cf[i]) begin
			wr(`CLU_A_CFG, {28'h0, cf[i]});
			wr(`CLU_A_TXD, 32'hA5);
			t = 2 + (cf[i][0] ? 8 : 7) + int'(cf[i][2:1] != 2'h0) + int'(cf[i][3]);
			term_u.recv(t, 80, fr);
			ck("tx frame", fr, frm(8'hA5, cf[i][0] ? 8 : 7, cf[i][2:1]));
			repeat (160) @(posedge clk_sys);
		end
		wr(`CLU_A_CFG, 32'h2);
		wr(`CLU_A_STAT, 32'h7F);
		term_u.send(frm(8'hC3, 7, 2'h1), 10, 80);
		repeat (20) @(posedge clk_sys);
		rd(`CLU_A_RXD, 32'h43, "rx char");
		rd(`CLU_A_STAT, 32'h1, "rx stat");
		// Flip parity, then stop bit
		for (int k = 0; k < 2; k++) begin
			term_u.send(frm(8'h55, 7, 2'h1) ^ (12'h100 << k), 10, 80);
			repeat (80) @(posedge clk_sys);
			apb(1'b0, `CLU_A_STAT, 32'h0);
			ck("rx errors", rv[3:2], 1 << k);
			wr(`CLU_A_STAT, 32'h7F);
		end
		wr(`CLU_A_IDLE, 32'h2);
		t = 0;
		while (session_end !== 1'b1 && t < 200) begin
			@(posedge clk_sys);
			t++;
		end
		ck("idle span", t > 36 && t < 44, 1);
		rd(`CLU_A_STAT, 32'h20, "idle stat");
		wr(`CLU_A_THR, 32'd121);
		ck("thr err", er, 1);
		wr(`CLU_A_THR, 32'h2);
		wr(`CLU_A_SIL, 32'h3);
		wr(`CLU_A_LOGON, 32'h1);
		rd(`CLU_A_LOGON, 32'h80, "fail count");
		wr(`CLU_A_LOGON, 32'h1);
		rd(`CLU_A_LOGON, 32'h1, "silent");
		wr(`CLU_A_LOGON, 32'h1);
		rd(`CLU_A_LOGON, 32'h1, "ignored");
		t = 0;
		while (logon_silent === 1'b1 && t < 200) begin
			@(posedge clk_sys);
			t++;
		end
		ck("silent span", t > 42 && t < 56, 1);
		rd(`CLU_A_STAT, 32'h60, "lock stat");
		wr(`CLU_A_LOGON, 32'h1);
		rd(`CLU_A_LOGON, 32'h80, "after silent");
		end_of_test();
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (60000) @(posedge clk_sys);
		errors++;
		end_of_test();
	end
endmodule : tb_console_line_uart
